// File: logic/cpu_regfile_pkg.sv
// Constants, types and helpers shared by the CPU register file.
//==============================================================================
// Notes on behaviour
// [RULE_01] Registers 0-11, status and config are 16 bits; 12, 13, return address, stack pointer and both aux stack pointers are 32 bits; the program counter is 24 bits.
// [RULE_02] Sixteen general registers, each usable alone as 16 bits or paired for wider addresses.
// [RULE_03] With pair-compat set, pairs run 1:0 up to 11:10, then low halves of 12, 13, 14 chain in overlapping pairs, the top one being the extended return address.
// [RULE_04] With pair-compat clear, pairs run up to 11 with the low half of 12, and 12, 13, return address and stack pointer are full 32-bit holders.
// [RULE_05] A byte operation touches only the low byte of the named register.
// [RULE_06] A word operation on a pair or wide register touches only its lower word.
// [RULE_07] Software writes zero into reserved bit positions.
// [RULE_08] Reserved bits read back with no defined value.
// [RULE_09] The program counter holds the current instruction address and its bit 0 reads as 0.
// [RULE_10] Reset loads the program counter with 0 or an alternative preset start.
// [RULE_11] Warm reset copies the prior program counter into the pair 1:0.
// [RULE_12] Operand reads and result write-back each fit in one cycle.
// [RULE_13] Exactly four dedicated address registers: program counter, interrupt stack, user stack and dispatch table base.
// [RULE_14] The interrupt stack pointer keeps bit 0 and its top 8 bits at zero.
// [RULE_15] Every config bit clears on reset, so native pairing follows reset.
// [RULE_16] A 32-bit or pair write updates both halves on the same edge.
package cpu_regfile_pkg;

    //==========================================================================
    // Widths and indices
    localparam int          NUM_GPR            = 16;
    localparam int          NUM_WIDE           = 4;
    localparam logic [3:0]  WIDE_FIRST_NATIVE  = 4'hc;
    localparam logic [3:0]  WIDE_FIRST_COMPAT  = 4'he;
    localparam logic [3:0]  GPR_STATUS_COPY    = 4'h2;

    //==========================================================================
    // Field positions, masks and reset values
    localparam int          CFG_PAIR_BIT       = 9;
    localparam logic [15:0] CFG_MASK           = 16'h0300;
    localparam logic [15:0] CFG_RESET          = 16'h0000;
    localparam logic [15:0] PSW_MASK           = 16'h0eef;
    localparam logic [15:0] PSW_RESET          = 16'h0200;
    localparam logic [31:0] ISP_MASK           = 32'h00ff_fffe;
    localparam logic [23:0] PC_MASK            = 24'hff_fffe;
    localparam logic [23:0] PC_RESET_ZERO      = 24'h00_0000;
    localparam logic [23:0] PC_RESET_ALT       = 24'h00_1000;

    //==========================================================================
    // Operation sizes and dedicated register selects
    typedef enum logic [1:0] {
        SZ_BYTE  = 2'h0,
        SZ_WORD  = 2'h1,
        SZ_DWORD = 2'h2
    } op_size_e;

    typedef enum logic [2:0] {
        DED_PC   = 3'h0,
        DED_ISP  = 3'h1,
        DED_USP  = 3'h2,
        DED_DTB  = 3'h3,
        DED_PSW  = 3'h4,
        DED_CFG  = 3'h5
    } ded_sel_e;

    // True when a double-word operation on idx uses one full 32-bit register.
    function automatic logic is_full_reg(input logic [3:0] idx,
                                         input logic       compat);
        return (idx >= WIDE_FIRST_COMPAT) ||
               (!compat && (idx >= WIDE_FIRST_NATIVE));
    endfunction : is_full_reg

endpackage : cpu_regfile_pkg

// File: logic/operand_select.sv
// Operand read multiplexer: resolves a register index and size to a value.
`timescale 1ns/1ps
module operand_select
    import cpu_regfile_pkg::*;
(
    input  wire logic [NUM_GPR-1:0][15:0]  i_lo,
    input  wire logic [NUM_WIDE-1:0][15:0] i_hi,
    input  wire logic                      i_pair_compat_select,
    input  wire logic [3:0]                i_idx,
    input  wire op_size_e                  i_size,
    output logic      [31:0]               o_data
);

    logic [15:0] low_w;
    logic [15:0] up_w;

    always_comb begin
        low_w = i_lo[i_idx];
        up_w  = 16'h0000;
        if (is_full_reg(i_idx, i_pair_compat_select)) begin
            up_w = i_hi[i_idx[1:0]];                            // [RULE_04]
        end else if (i_idx != 4'hf) begin
            up_w = i_lo[i_idx + 4'h1];                          // [RULE_03]
        end
        unique case (i_size)
            SZ_BYTE: o_data = {24'h00_0000, low_w[7:0]};        // [RULE_05]
            SZ_WORD: o_data = {16'h0000, low_w};                // [RULE_06]
            default: o_data = {up_w, low_w};
        endcase
    end

endmodule : operand_select

// File: logic/cpu_register_file.sv
// Architectural register file with pairing, dedicated and control registers.
`timescale 1ns/1ps
module cpu_register_file
    import cpu_regfile_pkg::*;
#(
    parameter bit USE_ALT_START = 1'b0
)(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_warm_rst,
    input  wire logic [3:0]  i_rd_a_idx,
    input  wire op_size_e    i_rd_a_size,
    input  wire logic [3:0]  i_rd_b_idx,
    input  wire op_size_e    i_rd_b_size,
    input  wire logic        i_wr_en,
    input  wire logic [3:0]  i_wr_idx,
    input  wire op_size_e    i_wr_size,
    input  wire logic [31:0] i_wr_data,
    input  wire logic        i_ded_wr_en,
    input  wire ded_sel_e    i_ded_sel,
    input  wire logic [31:0] i_ded_wr_data,
    output logic      [31:0] o_rd_a_data,
    output logic      [31:0] o_rd_b_data,
    output logic      [23:0] o_program_counter,
    output logic      [31:0] o_interrupt_stack_ptr,
    output logic      [31:0] o_user_stack_ptr,
    output logic      [31:0] o_dispatch_table_base,
    output logic      [15:0] o_processor_status_word,
    output logic      [15:0] o_config_word,
    output logic             o_pair_compat_select
);

    //==========================================================================
    // State
    localparam logic [23:0] PC_START = USE_ALT_START ? PC_RESET_ALT
                                                     : PC_RESET_ZERO;

    typedef struct packed {
        logic [NUM_GPR-1:0][15:0]  lo;   // All sixteen low halves. [RULE_02]
        logic [NUM_WIDE-1:0][15:0] hi;   // Upper halves of 12, 13, 14, 15.
        logic [23:0]               pc;
        logic [31:0]               interrupt_stack_ptr;
        logic [31:0]               user_stack_ptr;
        logic [31:0]               dtb;
        logic [15:0]               psw;
        logic [15:0]               cfg;
        logic [31:0]               rda;
        logic [31:0]               rdb;
    } state_s;

    state_s      state_q;
    state_s      state_d;
    logic [31:0] rd_a_val;
    logic [31:0] rd_b_val;
    logic        compat;
    logic [15:0] wr_up;
    logic [3:0]  wr_nb;
    logic [23:0] ded_pc;
    logic [15:0] ded_lo;

    assign compat = state_q.cfg[CFG_PAIR_BIT];
    assign wr_up  = i_wr_data[31:16];
    assign wr_nb  = i_wr_idx + 4'h1;
    assign ded_pc = i_ded_wr_data[23:0];
    assign ded_lo = i_ded_wr_data[15:0];

    //==========================================================================
    // Read ports
    // Reads see the state before this edge's write; the pipeline forwards
    // a result needed in the very next instruction itself.
    operand_select u_rd_a (
        .i_lo                 (state_q.lo),
        .i_hi                 (state_q.hi),
        .i_pair_compat_select (compat),
        .i_idx                (i_rd_a_idx),
        .i_size               (i_rd_a_size),
        .o_data               (rd_a_val)
    );

    operand_select u_rd_b (
        .i_lo                 (state_q.lo),
        .i_hi                 (state_q.hi),
        .i_pair_compat_select (compat),
        .i_idx                (i_rd_b_idx),
        .i_size               (i_rd_b_size),
        .o_data               (rd_b_val)
    );

    //==========================================================================
    // Next state
    always_comb begin
        state_d     = state_q;
        state_d.rda = rd_a_val;                                 // [RULE_12]
        state_d.rdb = rd_b_val;                                 // [RULE_12]

        if (i_wr_en) begin
            unique case (i_wr_size)
                SZ_BYTE: begin
                    state_d.lo[i_wr_idx][7:0] = i_wr_data[7:0]; // [RULE_05]
                end
                SZ_WORD: begin
                    state_d.lo[i_wr_idx] = i_wr_data[15:0];     // [RULE_06]
                end
                default: begin
                    state_d.lo[i_wr_idx] = i_wr_data[15:0];
                    if (is_full_reg(i_wr_idx, compat)) begin
                        state_d.hi[i_wr_idx[1:0]] = wr_up;    // [RULE_16]
                    end else begin
                        state_d.lo[wr_nb] = wr_up;            // [RULE_03]
                    end
                end
            endcase
        end

        // Reserved and constant-zero bits are not stored, so they read 0.
        if (i_ded_wr_en) begin
            unique case (i_ded_sel)
                DED_PC:  state_d.pc  = ded_pc & PC_MASK;         // [RULE_09]
                DED_ISP: state_d.interrupt_stack_ptr = i_ded_wr_data & ISP_MASK; // [RULE_14]
                DED_USP: state_d.user_stack_ptr = i_ded_wr_data;            // [RULE_13]
                DED_DTB: state_d.dtb = i_ded_wr_data;            // [RULE_13]
                DED_PSW: state_d.psw = ded_lo & PSW_MASK;        // [RULE_08]
                DED_CFG: state_d.cfg = ded_lo & CFG_MASK;        // [RULE_08]
                default: state_d.cfg = state_q.cfg;
            endcase
        end

        // Warm reset wins over any write in the same cycle to registers 0-2, pc, psw and cfg.
        if (i_warm_rst) begin
            state_d.lo[0]  = state_q.pc[15:0];                  // [RULE_11]
            state_d.lo[1]  = {8'h00, state_q.pc[23:16]};        // [RULE_11]
            state_d.lo[GPR_STATUS_COPY] = state_q.psw;
            state_d.pc     = PC_START;                          // [RULE_10]
            state_d.psw    = PSW_RESET;
            state_d.cfg    = CFG_RESET;                         // [RULE_15]
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q     <= '0;
            state_q.pc  <= PC_START;                            // [RULE_10]
            state_q.psw <= PSW_RESET;
            state_q.cfg <= CFG_RESET;                           // [RULE_15]
        end else begin
            state_q <= state_d;
        end
    end

    //==========================================================================
    // Outputs
    assign o_rd_a_data             = state_q.rda;
    assign o_rd_b_data             = state_q.rdb;
    assign o_program_counter       = state_q.pc;                // [RULE_01]
    assign o_interrupt_stack_ptr   = state_q.interrupt_stack_ptr;
    assign o_user_stack_ptr        = state_q.user_stack_ptr;
    assign o_dispatch_table_base   = state_q.dtb;
    assign o_processor_status_word = state_q.psw;
    assign o_config_word           = state_q.cfg;
    assign o_pair_compat_select    = compat;

    //==========================================================================
    // Assertions
    a_pc_even_bit: assert property ( // [RULE_09]
        @(posedge i_clk) disable iff (!i_rst_n)
        o_program_counter[0] == 1'b0)
        else $error("program counter bit 0 is set");

    a_isp_zero_bits: assert property ( // [RULE_14]
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ded_wr_en && i_ded_sel == DED_ISP && !i_warm_rst)
        |=> o_interrupt_stack_ptr == ($past(i_ded_wr_data) & ISP_MASK))
        else $error("interrupt stack pointer not masked on write");

    a_byte_upper_kept: assert property ( // [RULE_05]
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_wr_en && i_wr_size == SZ_BYTE && !i_warm_rst && i_wr_idx > 4'h2)
        |=> state_q.lo[$past(i_wr_idx)] ==
            {$past(state_q.lo[i_wr_idx][15:8]), $past(i_wr_data[7:0])})
        else $error("byte write disturbed the upper byte");

    a_word_upper_kept: assert property ( // [RULE_06]
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_wr_en && i_wr_size == SZ_WORD && i_wr_idx >= WIDE_FIRST_NATIVE)
        |=> $stable(state_q.hi))
        else $error("word write changed an upper word");

    a_full_both_halves: assert property ( // [RULE_16]
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_wr_en && i_wr_size == SZ_DWORD && !i_warm_rst &&
         is_full_reg(i_wr_idx, compat))
        |=> {state_q.hi[$past(i_wr_idx[1:0])], state_q.lo[$past(i_wr_idx)]}
            == $past(i_wr_data))
        else $error("32-bit register write incomplete");

    a_compat_pair_write: assert property ( // [RULE_03]
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_wr_en && i_wr_size == SZ_DWORD && !i_warm_rst && compat &&
         i_wr_idx == 4'hc)
        |=> state_q.lo[13] == $past(i_wr_data[31:16]) && $stable(state_q.hi))
        else $error("compatible pair write went to the wrong halves");

    a_warm_pc_copy: assert property ( // [RULE_11]
        @(posedge i_clk) disable iff (!i_rst_n)
        i_warm_rst |=> {state_q.lo[1][7:0], state_q.lo[0]}
                       == $past(o_program_counter))
        else $error("warm reset did not save the program counter");

    a_warm_reload: assert property ( // [RULE_15]
        @(posedge i_clk) disable iff (!i_rst_n)
        i_warm_rst |=> o_program_counter == PC_START &&
                       o_config_word == CFG_RESET && !o_pair_compat_select)
        else $error("warm reset did not reload start state");

    a_byte_read_zero: assert property ( // [RULE_12]
        @(posedge i_clk) disable iff (!i_rst_n)
        i_rd_a_size == SZ_BYTE
        |=> o_rd_a_data == {24'h00_0000, $past(state_q.lo[i_rd_a_idx][7:0])})
        else $error("byte read did not arrive one cycle later");

endmodule : cpu_register_file

// File: test/exec_pipe_model.sv
// Random request stream standing in for the execution pipeline.
`timescale 1ns/1ps
module exec_pipe_model
    import cpu_regfile_pkg::*;
(
    input  wire logic        i_clk,
    output logic      [3:0]  o_ra_idx,
    output logic      [1:0]  o_ra_size,
    output logic      [3:0]  o_rb_idx,
    output logic      [1:0]  o_rb_size,
    output logic             o_wr_en,
    output logic      [3:0]  o_wr_idx,
    output logic      [1:0]  o_wr_size,
    output logic      [31:0] o_wr_data,
    output logic             o_ded_en,
    output logic      [2:0]  o_ded_sel,
    output logic      [31:0] o_ded_data
);
    //==========================================================
    // Generator
    integer      seed = 32'h67e3;
    logic [31:0] d;
    logic [2:0]  s;

    // Size code 3 is never issued; its meaning is a local choice.
    always @(negedge i_clk) begin
        o_ra_idx  <= 4'($random(seed));
        o_ra_size <= 2'($unsigned($random(seed)) % 3);
        o_rb_idx  <= 4'($random(seed));
        o_rb_size <= 2'($unsigned($random(seed)) % 3);
        o_wr_en   <= 1'($random(seed));
        o_wr_idx  <= 4'($random(seed));
        o_wr_size <= 2'($unsigned($random(seed)) % 3);
        o_wr_data <= $random(seed);
        s = 3'($unsigned($random(seed)) % 6);
        d = $random(seed);
        if (s == DED_DTB) d = d & 32'h00ff_fffe;
        if (s == DED_PSW) d = d & 32'h0000_0eef;
        if (s == DED_CFG) d = d & 32'h0000_0300;
        o_ded_en   <= 3'($random(seed)) == 3'h0;
        o_ded_sel  <= s;
        o_ded_data <= d;
    end
endmodule : exec_pipe_model

// File: test/tb_top.sv
// Self-checking bench for the CPU register file against a shadow model.
`timescale 1ns/1ps
module tb_top
    import cpu_regfile_pkg::*;
;
    //==========================================================
    // Signals
    typedef struct packed {
        logic [3:0]  ra_idx, rb_idx, wr_idx;
        logic [1:0]  ra_size, rb_size, wr_size;
        logic        wr_en, ded_en, warm;
        logic [31:0] wr_data, ded_data;
        logic [2:0]  ded_sel;
    } req_s;
    localparam bit          ALT = 1'b1;
    localparam logic [23:0] PC0 = ALT ? PC_RESET_ALT : PC_RESET_ZERO;
    // Reserved positions carry no defined value, so compares leave them out.
    localparam logic [15:0] PSW_DEF = 16'h0fff;
    localparam logic [15:0] CFG_DEF = 16'h03c3;
    logic        i_clk = 1'b0;
    logic        i_rst_n, run, chk_on;
    req_s        t;
    wire req_s   p;
    wire req_s   q = run ? p : t;
    logic [36:0] pd;
    logic [15:0] lo [16];
    logic [15:0] hi [4];
    logic [23:0] pc;
    logic [31:0] interrupt_stack_ptr, user_stack_ptr, dtb, ea, eb;
    logic [15:0] psw, cfg;
    wire  [31:0] o_ra, o_rb, o_isp, o_usp, o_dtb;
    wire  [23:0] o_pc;
    wire  [15:0] o_psw, o_cfg;
    wire         o_cmp;
    int          error_cnt = 0;
    int          n_compared = 0;

    always #20 i_clk = ~i_clk;
    assign p.warm = 1'b0;

    exec_pipe_model pm (.i_clk(i_clk), .o_ra_idx(p.ra_idx),
        .o_ra_size(p.ra_size), .o_rb_idx(p.rb_idx), .o_rb_size(p.rb_size),
        .o_wr_en(p.wr_en), .o_wr_idx(p.wr_idx), .o_wr_size(p.wr_size),
        .o_wr_data(p.wr_data), .o_ded_en(p.ded_en), .o_ded_sel(p.ded_sel),
        .o_ded_data(p.ded_data));

    cpu_register_file #(.USE_ALT_START(ALT)) uut (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_warm_rst(q.warm), .i_rd_a_idx(q.ra_idx),
        .i_rd_a_size(op_size_e'(q.ra_size)), .i_rd_b_idx(q.rb_idx),
        .i_rd_b_size(op_size_e'(q.rb_size)), .i_wr_en(q.wr_en),
        .i_wr_idx(q.wr_idx), .i_wr_size(op_size_e'(q.wr_size)),
        .i_wr_data(q.wr_data), .i_ded_wr_en(q.ded_en),
        .i_ded_sel(ded_sel_e'(q.ded_sel)), .i_ded_wr_data(q.ded_data),
        .o_rd_a_data(o_ra), .o_rd_b_data(o_rb), .o_program_counter(o_pc),
        .o_interrupt_stack_ptr(o_isp), .o_user_stack_ptr(o_usp),
        .o_dispatch_table_base(o_dtb), .o_processor_status_word(o_psw),
        .o_config_word(o_cfg), .o_pair_compat_select(o_cmp));

    //==========================================================
    // Shadow model
    function automatic logic full(input logic [3:0] i);
        return i >= 4'he || (!cfg[9] && i >= 4'hc);
    endfunction : full

    function automatic logic [31:0] rd(input logic [3:0] i,
                                       input logic [1:0] s);
        if (s == SZ_BYTE) return {24'h0, lo[i][7:0]};
        if (s == SZ_WORD) return {16'h0, lo[i]};
        if (full(i)) return {hi[i[1:0]], lo[i]};
        return {lo[i+4'h1], lo[i]};
    endfunction : rd

    // Software keeps reserved positions at zero on every write.
    function automatic logic [31:0] legal_ones(input int s);
        case (s)
            3:       return 32'h00ff_fffe;
            4:       return 32'h0000_0fff;
            5:       return 32'h0000_03c3;
            default: return 32'hffff_ffff;
        endcase
    endfunction : legal_ones

    // Reads see the state before this edge's writes; no bypass.
    always @(posedge i_clk or negedge i_rst_n) begin : model
        logic [23:0] opc;
        logic [15:0] opsw;
        opc = pc;
        opsw = psw;
        if (!i_rst_n) begin
            lo = '{default: 16'h0};
            hi = '{default: 16'h0};
            {interrupt_stack_ptr, user_stack_ptr, dtb, ea, eb, cfg} = '0;
            pc = PC0;
            psw = PSW_RESET;
        end else begin
            ea = rd(q.ra_idx, q.ra_size);
            eb = rd(q.rb_idx, q.rb_size);
            if (q.wr_en && q.wr_size == SZ_BYTE) begin
                lo[q.wr_idx][7:0] = q.wr_data[7:0];
            end else if (q.wr_en) begin
                lo[q.wr_idx] = q.wr_data[15:0];
                if (q.wr_size == SZ_WORD) begin
                end else if (full(q.wr_idx)) begin
                    hi[q.wr_idx[1:0]] = q.wr_data[31:16];
                end else begin
                    lo[q.wr_idx+4'h1] = q.wr_data[31:16];
                end
            end
            if (q.ded_en) begin
                case (q.ded_sel)
                    DED_PC:  pc = q.ded_data[23:0] & PC_MASK;
                    DED_ISP: interrupt_stack_ptr = q.ded_data & ISP_MASK;
                    DED_USP: user_stack_ptr = q.ded_data;
                    DED_DTB: dtb = q.ded_data;
                    DED_PSW: psw = q.ded_data[15:0] & PSW_MASK;
                    DED_CFG: cfg = q.ded_data[15:0] & CFG_MASK;
                    default: ;
                endcase
            end
            if (q.warm) begin
                {lo[2], lo[1], lo[0]} = {opsw, 8'h0, opc};
                {pc, psw, cfg} = {PC0, PSW_RESET, 16'h0};
            end
        end
    end

    //==========================================================
    // Checking and verdict
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    always @(negedge i_clk) begin
        if (chk_on) begin
            chk("rd_a", o_ra, ea);
            chk("rd_b", o_rb, eb);
            chk("pc", {8'h0, o_pc}, {8'h0, pc});
            chk("isp", o_isp, interrupt_stack_ptr);
            chk("usp", o_usp, user_stack_ptr);
            chk("dtb", o_dtb, dtb);
            chk("psw", 32'(o_psw & PSW_DEF), 32'(psw & PSW_DEF));
            chk("cfg", 32'(o_cfg & CFG_DEF), 32'(cfg & CFG_DEF));
            chk("compat", {31'h0, o_cmp}, {31'h0, cfg[9]});
        end
    end

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    task automatic go(input logic we, input logic [3:0] wi,
                      input logic [1:0] ws, input logic [31:0] wd,
                      input logic [3:0] ri, input logic [1:0] rs);
        {t.wr_en, t.wr_idx, t.wr_size, t.wr_data} = {we, wi, ws, wd};
        {t.ra_idx, t.ra_size, t.rb_idx, t.rb_size} = {ri, rs, wi, 2'h2};
        {t.ded_en, t.ded_sel, t.ded_data, t.warm} = pd;
        pd = '0;
        @(negedge i_clk);
    endtask : go

    initial begin
        repeat (3000) @(posedge i_clk);
        error_cnt++;
        conclude();
    end

    initial begin
        {t, pd, run, chk_on, i_rst_n} = '0;
        repeat (5) @(negedge i_clk);
        i_rst_n <= 1'b1;
        chk_on <= 1'b1;
        go(1, 4'hc, SZ_DWORD, 32'hdead_beef, 4'hc, SZ_DWORD);
        go(1, 4'hc, SZ_WORD, 32'h1111_2222, 4'hc, SZ_DWORD);
        go(1, 4'h3, SZ_DWORD, 32'h5566_7788, 4'hc, SZ_DWORD);
        go(1, 4'h3, SZ_BYTE, 32'hffff_ff00, 4'h3, SZ_DWORD);
        go(0, 4'h4, SZ_BYTE, 32'h0, 4'h3, SZ_WORD);
        // Ones everywhere but reserved positions show each keep mask.
        for (int s = 0; s < 8; s++) begin
            pd = {1'b1, 3'(s), legal_ones(s), 1'b0};
            go(1, 4'(2 * s), SZ_DWORD, 32'h0aaa_0bbb + s, 4'(s), SZ_BYTE);
        end
        go(1, 4'hb, SZ_DWORD, 32'h0ccc_0ddd, 4'hb, SZ_DWORD);
        go(1, 4'hd, SZ_DWORD, 32'h0eee_0fff, 4'hc, SZ_DWORD);
        go(0, 4'he, SZ_WORD, 32'h0, 4'hf, SZ_DWORD);
        pd = {1'b1, 3'h0, 32'h00ab_cdef, 1'b0};
        go(1, 4'h5, SZ_WORD, 32'h4321, 4'h5, SZ_WORD);
        pd = {1'b1, 3'h0, 32'h0000_4444, 1'b1};
        go(1, 4'h0, SZ_WORD, 32'h1234, 4'h1, SZ_WORD);
        go(0, 4'h0, SZ_DWORD, 32'h0, 4'h2, SZ_WORD);
        for (int m = 0; m < 2; m++) begin
            pd = {1'b1, 3'h5, 32'(m) << 9, 1'b0};
            go(0, 4'h0, SZ_WORD, 32'h0, 4'h0, SZ_WORD);
            run = 1'b1;
            repeat (500) @(negedge i_clk);
            run = 1'b0;
        end
        chk_on <= 1'b0;
        i_rst_n <= 1'b0;
        go(0, 4'h0, SZ_WORD, 32'h0, 4'h0, SZ_WORD);
        i_rst_n <= 1'b1;
        chk_on <= 1'b1;
        go(0, 4'hc, SZ_DWORD, 32'h0, 4'h1, SZ_DWORD);
        go(0, 4'h0, SZ_WORD, 32'h0, 4'h0, SZ_WORD);
        // Let the falling-edge checker see the last answer first.
        @(posedge i_clk);
        conclude();
    end
endmodule : tb_top
